// file: common/pib_consts.svh
// register offsets, bit positions and reset values of the peripheral interrupt bank
`ifndef PIB_CONSTS_SVH
`define PIB_CONSTS_SVH

// ***********************************************
// register map
// ***********************************************
`define PIB_ADDR_W 8
`define PIB_OFS_ENABLE_TWO 8'h11
`define PIB_OFS_FLAG_ONE 8'h16
`define PIB_OFS_ENABLE_ONE 8'h17
`define PIB_OFS_FLAG_TWO 8'h10
`define PIB_OFS_CORE_CTRL 8'h20

// ***********************************************
// bit positions
// ***********************************************
`define PIB_BIT_PORTB 7
`define PIB_BIT_TMR3 6
`define PIB_BIT_TMR2 5
`define PIB_BIT_TMR1 4
`define PIB_BIT_CAP2 3
`define PIB_BIT_CAP1 2
`define PIB_BIT_TX1 1
`define PIB_BIT_RX1 0
`define PIB_BIT_TWO_UNUSED 4
`define PIB_BIT_GROUP_EN 3
`define PIB_BIT_GLOBAL_DIS 4

// ***********************************************
// reset values and masks
// ***********************************************
`define PIB_RST_ENABLE_ONE 8'h00
`define PIB_RST_ENABLE_TWO 8'h00
`define PIB_RST_FLAG_ONE 8'h02
`define PIB_RST_FLAG_TWO 8'h02
`define PIB_RST_CORE_CTRL 8'h10
`define PIB_MASK_TWO 8'hef
`define PIB_SW_FLAG_ONE 8'hfc

`endif

// file: common/pib_pkg.sv
// shared types of the peripheral interrupt bank
package pib_pkg;
   typedef logic [7:0] pib_byte_t;
endpackage : pib_pkg

// file: src/pib_bank.sv
// peripheral interrupt enable and flag bank with combined request
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "pib_consts.svh"

// What this block does
// RULE1: bit 7 enables port-B change interrupt
// RULE2: bits 6-4 enable timers three, two, one
// RULE3: bits 3-2 enable captures two, one
// RULE4: bit 1 enables serial one transmit
// RULE5: bit 0 enables serial one receive
// RULE6: second enable register at 11h, bit 4 unused
// RULE7: port-B change sets flag; mismatch re-sets it
// RULE8: capture mode: timer three overflow sets flag
// RULE9: period mode: timer three period rollover sets flag
// RULE10: timer two period rollover sets flag
// RULE11: 8-bit mode: timer one rollover sets flag
// RULE12: 16-bit mode: cascaded rollover sets flag
// RULE13: capture two event sets bit 3
// RULE14: capture one event sets bit 2
// RULE15: transmit flag follows buffer empty state
// RULE16: receive flag follows buffer full state
// RULE17: first enable register at 17h
// RULE18: first flag register at 16h, matching bits
// RULE19: pending is OR of flag AND enable
// RULE20: group enable gates request to core
// RULE21: global disable blocks every interrupt
// RULE22: flags set regardless of enables; sw clears
module pib_bank (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // register port
   input wire logic [`PIB_ADDR_W-1:0] reg_addr,
   input wire pib_pkg::pib_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output pib_pkg::pib_byte_t reg_rdata,
   // peripheral events
   input wire logic portb_mismatch,
   input wire logic timer_three_overflow,
   input wire logic timer_three_period_roll,
   input wire logic capture_or_period_sel,
   input wire logic timer_two_period_roll,
   input wire logic timer_one_period_roll,
   input wire logic timer_cascade_roll,
   input wire logic timer_cascade_sel,
   input wire logic capture_two_pin,
   input wire logic capture_one_pin,
   input wire logic serial_one_tx_empty,
   input wire logic serial_one_rx_full,
   input wire pib_pkg::pib_byte_t flag_two_set,
   input wire logic [1:0] serial_two_state,
   // to core
   output logic peripheral_pending_flag,
   output logic peripheral_irq_req
);

   // ***********************************************
   // registers
   // ***********************************************
   pib_pkg::pib_byte_t enable_one_q;
   pib_pkg::pib_byte_t enable_two_q;
   pib_pkg::pib_byte_t flag_one_q;
   pib_pkg::pib_byte_t flag_two_q;
   pib_pkg::pib_byte_t core_ctrl_q;
   pib_pkg::pib_byte_t flag_one_set;
   pib_pkg::pib_byte_t flag_two_all;
   logic wr_en_one;
   logic wr_en_two;
   logic wr_flag_one;
   logic wr_flag_two;
   logic wr_core;
   logic pending_d;

   assign wr_en_one = ce && reg_wr && reg_addr == `PIB_OFS_ENABLE_ONE; // RULE17
   assign wr_en_two = ce && reg_wr && reg_addr == `PIB_OFS_ENABLE_TWO; // RULE6
   assign wr_flag_one = ce && reg_wr && reg_addr == `PIB_OFS_FLAG_ONE; // RULE18
   assign wr_flag_two = ce && reg_wr && reg_addr == `PIB_OFS_FLAG_TWO;
   assign wr_core = ce && reg_wr && reg_addr == `PIB_OFS_CORE_CTRL;

   // ***********************************************
   // enable registers
   // ***********************************************
   // each bit except unused bit 4 of enable two is a plain gate; no side effect on write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_one_q <= `PIB_RST_ENABLE_ONE;
      end else if (wr_en_one) begin
         enable_one_q <= reg_wdata; // RULE1 RULE2 RULE3 RULE4 RULE5
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_two_q <= `PIB_RST_ENABLE_TWO;
      end else if (wr_en_two) begin
         enable_two_q <= reg_wdata & `PIB_MASK_TWO; // RULE6
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_ctrl_q <= `PIB_RST_CORE_CTRL;
      end else if (wr_core) begin
         core_ctrl_q <= reg_wdata;
      end
   end

   // ***********************************************
   // flag set terms
   // ***********************************************
   always_comb begin
      flag_one_set = 8'h00;
      // mismatch held high keeps re-setting the flag
      flag_one_set[`PIB_BIT_PORTB] = portb_mismatch; // RULE7
      flag_one_set[`PIB_BIT_TMR3] = capture_or_period_sel ? timer_three_overflow // RULE8
                                                          : timer_three_period_roll; // RULE9
      flag_one_set[`PIB_BIT_TMR2] = timer_two_period_roll; // RULE10
      flag_one_set[`PIB_BIT_TMR1] = timer_cascade_sel ? timer_cascade_roll // RULE12
                                                      : timer_one_period_roll; // RULE11
      flag_one_set[`PIB_BIT_CAP2] = capture_two_pin; // RULE13
      flag_one_set[`PIB_BIT_CAP1] = capture_one_pin; // RULE14
   end

   // ***********************************************
   // flag registers
   // ***********************************************
   // set wins over a same-cycle software clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_one_q <= `PIB_RST_FLAG_ONE;
      end else if (ce) begin
         flag_one_q <= (wr_flag_one ? (reg_wdata & `PIB_SW_FLAG_ONE)
                                    : (flag_one_q & `PIB_SW_FLAG_ONE))
                       | flag_one_set; // RULE22
         flag_one_q[`PIB_BIT_TX1] <= serial_one_tx_empty; // RULE15
         flag_one_q[`PIB_BIT_RX1] <= serial_one_rx_full; // RULE16
      end
   end

   assign flag_two_all = (wr_flag_two ? reg_wdata : flag_two_q) | flag_two_set;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_two_q <= `PIB_RST_FLAG_TWO;
      end else if (ce) begin
         flag_two_q <= {flag_two_all[7:2], serial_two_state} & `PIB_MASK_TWO;
      end
   end

   // ***********************************************
   // combined request
   // ***********************************************
   assign pending_d = |(flag_one_q & enable_one_q) | |(flag_two_q & enable_two_q); // RULE19

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         peripheral_pending_flag <= 1'b0;
      end else if (ce) begin
         peripheral_pending_flag <= pending_d; // RULE19
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         peripheral_irq_req <= 1'b0;
      end else if (ce) begin
         peripheral_irq_req <= pending_d && core_ctrl_q[`PIB_BIT_GROUP_EN] // RULE20
                               && !core_ctrl_q[`PIB_BIT_GLOBAL_DIS]; // RULE21
      end
   end

   // ***********************************************
   // read port
   // ***********************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         if (reg_rd) begin
            case (reg_addr)
               `PIB_OFS_ENABLE_ONE: reg_rdata <= enable_one_q;
               `PIB_OFS_ENABLE_TWO: reg_rdata <= enable_two_q;
               `PIB_OFS_FLAG_ONE: reg_rdata <= flag_one_q;
               `PIB_OFS_FLAG_TWO: reg_rdata <= flag_two_q;
               `PIB_OFS_CORE_CTRL: reg_rdata <= core_ctrl_q;
               default: reg_rdata <= 8'h00;
            endcase
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   property p_en_one_write;
      @(posedge clk) disable iff (rst)
      wr_en_one |=> enable_one_q == $past(reg_wdata);
   endproperty
   a_en_one_write: assert property (p_en_one_write) else $error("enable one write lost"); // RULE1

   property p_en_two_hole;
      @(posedge clk) disable iff (rst)
      enable_two_q[`PIB_BIT_TWO_UNUSED] == 1'b0;
   endproperty
   a_en_two_hole: assert property (p_en_two_hole) else $error("unused enable bit set"); // RULE6

   property p_portb_set;
      @(posedge clk) disable iff (rst)
      ce && portb_mismatch |=> flag_one_q[`PIB_BIT_PORTB];
   endproperty
   a_portb_set: assert property (p_portb_set) else $error("port-B flag not set"); // RULE7

   property p_tmr3_cap;
      @(posedge clk) disable iff (rst)
      ce && capture_or_period_sel && timer_three_overflow |=> flag_one_q[`PIB_BIT_TMR3];
   endproperty
   a_tmr3_cap: assert property (p_tmr3_cap) else $error("timer three flag missed"); // RULE8

   property p_tmr1_casc;
      @(posedge clk) disable iff (rst)
      ce && timer_cascade_sel && timer_cascade_roll |=> flag_one_q[`PIB_BIT_TMR1];
   endproperty
   a_tmr1_casc: assert property (p_tmr1_casc) else $error("cascade flag missed"); // RULE12

   property p_cap1_set;
      @(posedge clk) disable iff (rst)
      ce && capture_one_pin |=> flag_one_q[`PIB_BIT_CAP1];
   endproperty
   a_cap1_set: assert property (p_cap1_set) else $error("capture one flag missed"); // RULE14

   property p_tx_follow;
      @(posedge clk) disable iff (rst)
      ce |=> flag_one_q[`PIB_BIT_TX1] == $past(serial_one_tx_empty);
   endproperty
   a_tx_follow: assert property (p_tx_follow) else $error("transmit flag off state"); // RULE15

   property p_rx_follow;
      @(posedge clk) disable iff (rst)
      ce |=> flag_one_q[`PIB_BIT_RX1] == $past(serial_one_rx_full);
   endproperty
   a_rx_follow: assert property (p_rx_follow) else $error("receive flag off state"); // RULE16

   property p_global_block;
      @(posedge clk) disable iff (rst)
      core_ctrl_q[`PIB_BIT_GLOBAL_DIS] ##1 core_ctrl_q[`PIB_BIT_GLOBAL_DIS]
         |-> !peripheral_irq_req;
   endproperty
   a_global_block: assert property (p_global_block) else $error("request while masked"); // RULE21

   property p_en_one_keep;
      @(posedge clk) disable iff (rst)
      !wr_en_one |=> $stable(enable_one_q);
   endproperty
   a_en_one_keep: assert property (p_en_one_keep) else $error("enable one moved"); // RULE17

   property p_en_two_write;
      @(posedge clk) disable iff (rst)
      wr_en_two |=> enable_two_q == ($past(reg_wdata) & `PIB_MASK_TWO);
   endproperty
   a_en_two_write: assert property (p_en_two_write) else $error("enable two write lost"); // RULE6

   property p_tmr3_period;
      @(posedge clk) disable iff (rst)
      ce && !capture_or_period_sel && timer_three_period_roll |=> flag_one_q[`PIB_BIT_TMR3];
   endproperty
   a_tmr3_period: assert property (p_tmr3_period) else $error("timer three roll missed"); // RULE9

   property p_tmr2_set;
      @(posedge clk) disable iff (rst)
      ce && timer_two_period_roll |=> flag_one_q[`PIB_BIT_TMR2];
   endproperty
   a_tmr2_set: assert property (p_tmr2_set) else $error("timer two flag missed"); // RULE10

   property p_tmr1_own;
      @(posedge clk) disable iff (rst)
      ce && !timer_cascade_sel && timer_one_period_roll |=> flag_one_q[`PIB_BIT_TMR1];
   endproperty
   a_tmr1_own: assert property (p_tmr1_own) else $error("timer one flag missed"); // RULE11

   property p_cap2_set;
      @(posedge clk) disable iff (rst)
      ce && capture_two_pin |=> flag_one_q[`PIB_BIT_CAP2];
   endproperty
   a_cap2_set: assert property (p_cap2_set) else $error("capture two flag missed"); // RULE13

   property p_flag_clear;
      @(posedge clk) disable iff (rst)
      wr_flag_one && flag_one_set == 8'h00
         |=> (flag_one_q & `PIB_SW_FLAG_ONE) == ($past(reg_wdata) & `PIB_SW_FLAG_ONE);
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag write lost"); // RULE22

   property p_flag_sticky;
      @(posedge clk) disable iff (rst)
      ce && !wr_flag_one |=> (($past(flag_one_q) & ~flag_one_q) & `PIB_SW_FLAG_ONE) == 8'h00;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself"); // RULE22

   property p_flag_freeze;
      @(posedge clk) disable iff (rst)
      !ce |=> $stable(flag_one_q);
   endproperty
   a_flag_freeze: assert property (p_flag_freeze) else $error("flag moved while frozen"); // RULE22

   property p_pending_form;
      @(posedge clk) disable iff (rst)
      ce |=> peripheral_pending_flag
         == $past(|(flag_one_q & enable_one_q) || |(flag_two_q & enable_two_q));
   endproperty
   a_pending_form: assert property (p_pending_form) else $error("pending flag wrong"); // RULE19

   property p_req_gate;
      @(posedge clk) disable iff (rst)
      peripheral_irq_req |-> peripheral_pending_flag;
   endproperty
   a_req_gate: assert property (p_req_gate) else $error("request with nothing pending"); // RULE20

   property p_req_group;
      @(posedge clk) disable iff (rst)
      ce && !core_ctrl_q[`PIB_BIT_GROUP_EN] |=> !peripheral_irq_req;
   endproperty
   a_req_group: assert property (p_req_group) else $error("request with group off"); // RULE20

   property p_req_on;
      @(posedge clk) disable iff (rst)
      ce && core_ctrl_q[`PIB_BIT_GROUP_EN] && !core_ctrl_q[`PIB_BIT_GLOBAL_DIS]
         |=> peripheral_irq_req == peripheral_pending_flag;
   endproperty
   a_req_on: assert property (p_req_on) else $error("request not passed on"); // RULE20

   property p_read_flag;
      @(posedge clk) disable iff (rst)
      ce && reg_rd && reg_addr == `PIB_OFS_FLAG_ONE |=> reg_rdata == $past(flag_one_q);
   endproperty
   a_read_flag: assert property (p_read_flag) else $error("flag read wrong"); // RULE18

   property p_read_en_one;
      @(posedge clk) disable iff (rst)
      ce && reg_rd && reg_addr == `PIB_OFS_ENABLE_ONE |=> reg_rdata == $past(enable_one_q);
   endproperty
   a_read_en_one: assert property (p_read_en_one) else $error("enable one read wrong"); // RULE17

   property p_tmr3_mask;
      @(posedge clk) disable iff (rst)
      ce && capture_or_period_sel && !timer_three_overflow && !wr_flag_one
         && !flag_one_q[`PIB_BIT_TMR3] |=> !flag_one_q[`PIB_BIT_TMR3];
   endproperty
   a_tmr3_mask: assert property (p_tmr3_mask) else $error("period roll used in capture mode"); // RULE8

   property p_tmr1_mask;
      @(posedge clk) disable iff (rst)
      ce && timer_cascade_sel && !timer_cascade_roll && !wr_flag_one
         && !flag_one_q[`PIB_BIT_TMR1] |=> !flag_one_q[`PIB_BIT_TMR1];
   endproperty
   a_tmr1_mask: assert property (p_tmr1_mask) else $error("own roll used in cascade mode"); // RULE12

   property p_gate_portb;
      @(posedge clk) disable iff (rst)
      ce && flag_one_q[`PIB_BIT_PORTB] && enable_one_q[`PIB_BIT_PORTB] |=> peripheral_pending_flag;
   endproperty
   a_gate_portb: assert property (p_gate_portb) else $error("port-B request lost"); // RULE1

   property p_gate_tmr3;
      @(posedge clk) disable iff (rst)
      ce && flag_one_q[`PIB_BIT_TMR3] && enable_one_q[`PIB_BIT_TMR3] |=> peripheral_pending_flag;
   endproperty
   a_gate_tmr3: assert property (p_gate_tmr3) else $error("timer request lost"); // RULE2

   property p_gate_cap2;
      @(posedge clk) disable iff (rst)
      ce && flag_one_q[`PIB_BIT_CAP2] && enable_one_q[`PIB_BIT_CAP2] |=> peripheral_pending_flag;
   endproperty
   a_gate_cap2: assert property (p_gate_cap2) else $error("capture request lost"); // RULE3

   property p_gate_tx;
      @(posedge clk) disable iff (rst)
      ce && flag_one_q[`PIB_BIT_TX1] && enable_one_q[`PIB_BIT_TX1] |=> peripheral_pending_flag;
   endproperty
   a_gate_tx: assert property (p_gate_tx) else $error("transmit request lost"); // RULE4

   property p_gate_rx;
      @(posedge clk) disable iff (rst)
      ce && flag_one_q[`PIB_BIT_RX1] && enable_one_q[`PIB_BIT_RX1] |=> peripheral_pending_flag;
   endproperty
   a_gate_rx: assert property (p_gate_rx) else $error("receive request lost"); // RULE5

endmodule : pib_bank

// file: dv/pib_periph_model.sv
// behavioural peripheral side: one-cycle event pulses on request
`timescale 1ns/1ps
module pib_periph_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request from bench
   input wire logic fire,
   input wire logic [2:0] which,
   // event lines
   output logic [7:0] ev
);
   // ***********************************************
   // event pulses
   // ***********************************************
   // mismatch dropped after one cycle so the flag can stay cleared
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ev <= 8'h00;
      end else begin
         ev <= fire ? (8'h01 << which) : 8'h00;
      end
   end
endmodule : pib_periph_model

// file: dv/pib_bank_bench.sv
// self-checking bench of the peripheral interrupt bank
`timescale 1ns/1ps
`include "pib_consts.svh"
module pib_bank_bench;
   // ***********************************************
   // signals
   // ***********************************************
   logic clk = 0, rst = 1, rd = 0, wr = 0, fire = 0, cap_sel = 0, cas_sel = 0, ce = 1;
   logic tx_empty = 1, rx_full = 0, pend, req;
   logic [2:0] which = 0;
   logic [1:0] s2 = 0;
   logic [7:0] ev, addr = 0;
   pib_pkg::pib_byte_t wdata = 0, rdata, e, f2 = 0;
   int failures = 0, n_tests = 0, cycles = 0, i, j;
   int bitpos [8] = '{7, 6, 6, 5, 4, 4, 3, 2};

   initial begin
      forever #25 clk = ~clk;
   end

   pib_bank dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .portb_mismatch(ev[0]),
      .timer_three_overflow(ev[1]), .timer_three_period_roll(ev[2]),
      .capture_or_period_sel(cap_sel), .timer_two_period_roll(ev[3]),
      .timer_one_period_roll(ev[4]), .timer_cascade_roll(ev[5]), .timer_cascade_sel(cas_sel),
      .capture_two_pin(ev[6]), .capture_one_pin(ev[7]), .serial_one_tx_empty(tx_empty),
      .serial_one_rx_full(rx_full), .flag_two_set(f2), .serial_two_state(s2),
      .peripheral_pending_flag(pend), .peripheral_irq_req(req));

   pib_periph_model model_u (.clk(clk), .rst(rst), .fire(fire), .which(which), .ev(ev));

   // ***********************************************
   // tasks
   // ***********************************************
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input string name, input pib_pkg::pib_byte_t exp,
                        input pib_pkg::pib_byte_t got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] a, input pib_pkg::pib_byte_t v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // data stand only in the cycle after the strobe
   task automatic check_reg(input string name, input logic [7:0] a,
                            input pib_pkg::pib_byte_t exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(name, exp, rdata);
   endtask : check_reg

   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic event_fire(input int w);
      @(posedge clk);
      fire <= 1'b1;
      which <= w[2:0];
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : event_fire

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         conclude();
      end
   end

   // ***********************************************
   // tests
   // ***********************************************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      check_reg("enable_one", `PIB_OFS_ENABLE_ONE, 8'h00);
      check_reg("enable_two", `PIB_OFS_ENABLE_TWO, 8'h00);
      check_reg("flag_one", `PIB_OFS_FLAG_ONE, 8'h02);
      check_reg("unmapped", 8'h33, 8'h00);
      // second pass swaps the mode selects: those events must not count
      for (j = 0; j < 2; j++) begin
         for (i = 0; i < 8; i++) begin
            @(posedge clk);
            cap_sel <= ((i == 1) ^ (j == 1));
            cas_sel <= ((i == 5) ^ (j == 1));
            wr_reg(`PIB_OFS_FLAG_ONE, 8'h00);
            event_fire(i);
            e = (j == 1 && (i == 1 || i == 2 || i == 4 || i == 5)) ? 8'h02 :
                8'h02 | (8'h01 << bitpos[i]);
            check_reg("flag_event", `PIB_OFS_FLAG_ONE, e);
         end
      end
      settle();
      check("pending_masked", 8'h00, {7'h00, pend});
      wr_reg(`PIB_OFS_ENABLE_ONE, 8'h04);
      settle();
      check("pending_cap1", 8'h01, {7'h00, pend});
      check("req_disabled", 8'h00, {7'h00, req});
      wr_reg(`PIB_OFS_CORE_CTRL, 8'h08);
      settle();
      check("req_on", 8'h01, {7'h00, req});
      wr_reg(`PIB_OFS_CORE_CTRL, 8'h18);
      settle();
      check("req_global_off", 8'h00, {7'h00, req});
      wr_reg(`PIB_OFS_CORE_CTRL, 8'h00);
      settle();
      check("req_group_off", 8'h00, {7'h00, req});
      wr_reg(`PIB_OFS_FLAG_ONE, 8'h00);
      wr_reg(`PIB_OFS_ENABLE_ONE, 8'h02);
      settle();
      check("pending_tx", 8'h01, {7'h00, pend});
      @(posedge clk);
      tx_empty <= 1'b0;
      settle();
      check("pending_tx_full", 8'h00, {7'h00, pend});
      @(posedge clk);
      rx_full <= 1'b1;
      wr_reg(`PIB_OFS_ENABLE_ONE, 8'h01);
      settle();
      check("pending_rx", 8'h01, {7'h00, pend});
      wr_reg(`PIB_OFS_FLAG_ONE, 8'h00);
      check_reg("flag_serial", `PIB_OFS_FLAG_ONE, 8'h01);
      wr_reg(`PIB_OFS_ENABLE_ONE, 8'hff);
      check_reg("enable_one_rw", `PIB_OFS_ENABLE_ONE, 8'hff);
      wr_reg(`PIB_OFS_ENABLE_TWO, 8'hff);
      check_reg("enable_two_rw", `PIB_OFS_ENABLE_TWO, 8'hef);
      // clock enable low: the write must not land
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(`PIB_OFS_ENABLE_TWO, 8'h20);
      @(posedge clk);
      ce <= 1'b1;
      check_reg("enable_two_frozen", `PIB_OFS_ENABLE_TWO, 8'hef);
      // second flag register alone raises pending
      wr_reg(`PIB_OFS_ENABLE_ONE, 8'h00);
      wr_reg(`PIB_OFS_ENABLE_TWO, 8'h20);
      wr_reg(`PIB_OFS_FLAG_TWO, 8'h00);
      @(posedge clk);
      f2 <= 8'h20;
      s2 <= 2'h2;
      @(posedge clk);
      f2 <= 8'h00;
      settle();
      check("pending_two", 8'h01, {7'h00, pend});
      check_reg("flag_two", `PIB_OFS_FLAG_TWO, 8'h22);
      conclude();
   end
endmodule : pib_bank_bench
